// ===== logic/xip_pkg.sv
package xip_pkg;
  // timing
  localparam int unsigned CLK_MHZ     = 100;  // ref_clk rate
  localparam int unsigned PU_DELAY_US = 250;  // powerup_delay in us
  localparam int unsigned PU_CYC      = PU_DELAY_US * CLK_MHZ;
  // frame bit counts
  localparam logic [5:0] OPC_BITS = 6'h08;  // opcode and data byte
  localparam logic [5:0] ADR_BITS = 6'h18;  // address only
  localparam logic [5:0] ADM_BITS = 6'h20;  // address and mode
  localparam logic [5:0] NIB_BITS = 6'h04;  // bits per ddr edge
  localparam int unsigned LOC_BITS = 20;    // location bits used
  // opcodes, values arbitrary
  localparam logic [7:0] OP_RD_STAT1 = 8'h11;  // read_status_one_cmd
  localparam logic [7:0] OP_RD_ANY   = 8'h12;  // read_any_register_cmd
  localparam logic [7:0] OP_RD_XIP   = 8'h21;  // memory read, mode phase
  localparam logic [7:0] OP_WR_XIP   = 8'h22;  // memory write, mode phase
  localparam logic [7:0] OP_RD_DDR   = 8'h23;  // quad ddr read, mode phase
  localparam logic [7:0] OP_RD_PLAIN = 8'h24;  // memory read, no mode
  // mode byte keys
  localparam logic [3:0] KEY_HI = 4'ha;   // upper nibble key
  localparam logic [7:0] KEY_A5 = 8'ha5;  // full byte key
  // register fields
  localparam int unsigned MLAT_LSB  = 0;  // memory wait in cr1
  localparam int unsigned RLAT_LSB  = 0;  // register wait in cr2
  localparam int unsigned DPI_BIT   = 4;  // dual interface
  localparam int unsigned LINE3_BIT = 5;  // line3_reset_enable
  localparam int unsigned QPI_BIT   = 6;  // quad interface
  localparam int unsigned DEEP_BIT  = 2;  // deep_sleep_at_powerup
  localparam logic [1:0]  RLAT_MAX  = 2'h3;   // longest register wait
  localparam logic [7:0]  BOOT_SIG  = 8'h61;  // boot error signature
  localparam logic [23:0] RA_SR1_NV = 24'h000000;  // status one, nv
  localparam logic [23:0] RA_SR1_V  = 24'h070000;  // status one, volatile
  localparam logic [1:0]  SYNC_HI   = 2'h3;   // synchroniser idle high
  // carriers
  typedef struct packed {
    logic [7:0] sr1;  // status_register_one
    logic [7:0] cr1;  // config_register_one
    logic [7:0] cr2;  // config_register_two
    logic [7:0] cr4;  // config_register_four
  } cfg_t;
  typedef struct packed {
    logic [7:0]  sr2;       // status_register_two
    logic [7:0]  ecc_stat;  // error-correction status
    logic [15:0] ecc_cnt;   // error count
    logic [31:0] ecc_trap;  // error address trap
    logic [31:0] crc;       // checksum
  } err_t;
  typedef struct packed {
    logic ok;    // accepted
    logic rs1;   // status one read
    logic mode;  // has mode phase
    logic ddr;   // double data rate
    logic regs;  // register read
    logic rd;    // drives data
    logic a5;    // needs full key
  } op_t;
  localparam cfg_t CFG_RST = '{8'h00, 8'h00, 8'h00, 8'h00};
  localparam err_t ERR_RST = '{8'h00, 8'h00, 16'h0000, 32'h00000000, 32'h00000000};
  typedef enum logic [2:0] {
    PH_START = 3'b000, PH_OPC = 3'b001, PH_ADDR = 3'b010,
    PH_DUMMY = 3'b011, PH_DATA = 3'b100, PH_IGNORE = 3'b101
  } phase_t;
  typedef enum logic [2:0] {
    B_OFF = 3'b000, B_WAIT = 3'b001, B_RDY = 3'b010,
    B_STBY = 3'b011, B_DPD = 3'b100, B_ERR = 3'b101
  } boot_t;
endpackage

// ===== logic/xip_frontend.sv
`timescale 1ns/1ns
module xip_frontend
  import xip_pkg::*;
#(
  parameter int unsigned PU_CYCLES = PU_CYC  // powerup_delay in cycles
) (
  input  wire logic        ref_clk,     // system clock
  input  wire logic        reset_n,     // hardware reset
  input  wire logic        supply_ok,   // supply above minimum
  input  wire logic        boot_fault,  // trim load failed
  input  wire cfg_t        nv_cfg,      // non-volatile copies
  input  wire logic        sck,         // link clock
  input  wire logic        cs_n,        // chip select
  input  wire logic [3:0]  io_in,       // data lines in
  output logic      [3:0]  io_out,      // data lines out
  output logic      [3:0]  io_oe,       // data line enables
  output logic      [19:0] mem_addr,    // array location
  input  wire logic [7:0]  mem_rdata,   // array read byte
  output logic      [7:0]  wr_data,     // write byte
  output logic             wr_stb,      // write byte valid
  output cfg_t             cur_cfg,     // volatile registers
  output err_t             err_regs,    // error registers
  output logic             standby,     // in standby
  output logic             deep_pd,     // in deep power-down
  output logic             boot_error,  // boot failed
  output logic             xip_active,  // xip armed
  output logic             spi_mode3    // frame in mode 3
);

  // ---------------- system domain ----------------
  logic [1:0]  sup_s;      // supply synchroniser
  logic [1:0]  cs_s;       // select synchroniser
  logic [1:0]  flt_s;      // fault synchroniser
  logic [1:0]  xip_s;      // xip synchroniser
  logic [1:0]  m3_s;       // mode synchroniser
  boot_t       bst;        // boot state
  logic [31:0] pu_cnt;     // powerup_delay counter
  logic        pu_done;    // last delay cycle
  logic        link_en;    // link may answer
  logic        xip;        // execute_in_place armed, link domain
  logic        mode3;      // frame is mode 3, link domain

  // two-flop synchronisers for pins and link levels
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sup_s <= 2'h0;
      cs_s  <= SYNC_HI;
      flt_s <= 2'h0;
      xip_s <= 2'h0;
      m3_s  <= 2'h0;
    end else begin
      sup_s <= {sup_s[0], supply_ok};
      cs_s  <= {cs_s[0], cs_n};
      flt_s <= {flt_s[0], boot_fault};
      xip_s <= {xip_s[0], xip};
      m3_s  <= {m3_s[0], mode3};
    end
  end

  assign pu_done = (pu_cnt == 32'(PU_CYCLES - 1));

  // boot sequence
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bst    <= B_OFF;  // hardware reset restarts boot
      pu_cnt <= 32'h0;
    end else if (!sup_s[1]) begin
      bst    <= B_OFF;  // power cycle restarts boot
      pu_cnt <= 32'h0;
    end else begin
      unique case (bst)
        B_OFF: begin
          bst    <= B_WAIT;
          pu_cnt <= 32'h0;
        end
        B_WAIT: begin
          // hold off all access for the delay
          if (pu_done) begin
            bst <= flt_s[1] ? B_ERR : B_RDY;
          end else begin
            pu_cnt <= pu_cnt + 32'h1;
          end
        end
        B_RDY: begin
          // wait for deselect, then sleep or idle
          if (cs_s[1]) begin
            bst <= nv_cfg.cr4[DEEP_BIT] ? B_DPD : B_STBY;
          end
        end
        B_STBY, B_DPD, B_ERR: begin
          bst <= bst;  // left only by reset or power loss
        end
        default: begin
          bst <= B_OFF;  // illegal code
        end
      endcase
    end
  end

  // register load at end of delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_cfg  <= CFG_RST;
      err_regs <= ERR_RST;
    end else if (bst == B_WAIT && pu_done) begin
      err_regs <= ERR_RST;
      if (flt_s[1]) begin
        // fallback: single sdr, line3 reset, longest register wait
        cur_cfg.sr1 <= BOOT_SIG;
        cur_cfg.cr1 <= nv_cfg.cr1;
        cur_cfg.cr4 <= nv_cfg.cr4;
        cur_cfg.cr2 <= nv_cfg.cr2;
        cur_cfg.cr2[DPI_BIT]   <= 1'b0;
        cur_cfg.cr2[QPI_BIT]   <= 1'b0;
        cur_cfg.cr2[LINE3_BIT] <= 1'b1;
        cur_cfg.cr2[RLAT_LSB +: 2] <= RLAT_MAX;
      end else begin
        cur_cfg <= nv_cfg;  // user settings replace fallback
      end
    end
  end

  // status outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      standby    <= 1'b0;
      deep_pd    <= 1'b0;
      boot_error <= 1'b0;
      link_en    <= 1'b0;
      xip_active <= 1'b0;
      spi_mode3  <= 1'b0;
    end else begin
      standby    <= (bst == B_STBY);
      deep_pd    <= (bst == B_DPD);
      boot_error <= (bst == B_ERR);
      link_en    <= (bst == B_STBY) || (bst == B_ERR);
      xip_active <= xip_s[1];
      spi_mode3  <= m3_s[1];
    end
  end

  // ---------------- link domain ----------------
  logic [1:0]  en_s;      // link_en synchroniser
  phase_t      st;        // frame phase
  phase_t      ph;        // effective phase
  logic [5:0]  cnt;       // bits taken in phase
  logic [5:0]  next_cnt;  // bits after this edge
  logic [31:0] sh;        // input shifter
  logic [31:0] next_sh;   // shifter after this edge
  logic [23:0] addr;      // received address
  logic [3:0]  dly;       // wait cycles left
  logic [3:0]  wsel;      // wait for this op
  logic [7:0]  rbyte;     // register read byte
  logic        seen_rise; // rising edge seen in frame
  op_t         info;      // current operation
  op_t         new_inf;   // decoded opcode
  logic [2:0]  lw;        // interface lanes
  logic [5:0]  tgt;       // address phase length
  logic [3:0]  neg_nib;   // falling edge sample
  logic [7:0]  obyte;     // output shifter
  logic [3:0]  ocnt;      // output bits left
  logic [3:0]  out_neg;   // falling edge drive
  logic [3:0]  out_pos;   // rising edge drive
  logic [3:0]  dlo;       // ddr low nibble
  logic        ld_byte;   // output byte load
  logic [7:0]  src;       // next output byte

  // lanes in use for the configured interface
  function automatic logic [2:0] lanes_f(input logic [7:0] c2);
    if (c2[QPI_BIT]) begin
      lanes_f = 3'h4;
    end else if (c2[DPI_BIT]) begin
      lanes_f = 3'h2;
    end else begin
      lanes_f = 3'h1;
    end
  endfunction

  // shift in one edge of sdr data
  function automatic logic [31:0] take_f(input logic [31:0] s,
                                         input logic [3:0]  d,
                                         input logic [2:0]  w);
    unique case (w)
      3'h4:    take_f = {s[27:0], d};
      3'h2:    take_f = {s[29:0], d[1:0]};
      default: take_f = {s[30:0], d[0]};
    endcase
  endfunction

  // top bits of a byte onto the lines
  function automatic logic [3:0] drive_f(input logic [7:0] b,
                                         input logic [2:0] w);
    unique case (w)
      3'h4:    drive_f = b[7:4];
      3'h2:    drive_f = {2'h0, b[7:6]};
      default: drive_f = {2'h0, b[7], 1'b0};  // single line is io1
    endcase
  endfunction

  // opcode decode; boot error leaves only two reads
  function automatic op_t dec_f(input logic [7:0] op, input logic berr);
    dec_f = '0;
    unique case (op)
      OP_RD_STAT1: dec_f = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      OP_RD_ANY:   dec_f = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      OP_RD_XIP:   dec_f = '{!berr, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      OP_WR_XIP:   dec_f = '{!berr, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_RD_DDR:   dec_f = '{!berr, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      OP_RD_PLAIN: dec_f = '{!berr, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      default:     dec_f = '0;
    endcase
  endfunction

  assign lw      = lanes_f(cur_cfg.cr2);
  assign tgt     = info.mode ? ADM_BITS : ADR_BITS;
  assign new_inf = dec_f(next_sh[7:0], boot_error);
  assign wsel    = info.regs ? {2'h0, cur_cfg.cr2[RLAT_LSB +: 2]}
                             : cur_cfg.cr1[MLAT_LSB +: 4];

  // effective phase at the first edge of a frame
  always_comb begin
    ph = st;
    if (st == PH_START) begin
      if (!en_s[1]) begin
        ph = PH_IGNORE;  // still booting or in deep power-down
      end else if (xip) begin
        ph = PH_ADDR;  // opcode skipped
      end else begin
        ph = PH_OPC;  // opcode is first byte
      end
    end
  end

  // input assembly, sdr or ddr
  always_comb begin
    next_sh  = take_f(sh, io_in, lw);
    next_cnt = cnt + {3'h0, lw};
    if (ph == PH_OPC) begin
      next_sh  = take_f(sh, io_in, boot_error ? 3'h1 : lw);
      next_cnt = cnt + (boot_error ? 6'h01 : {3'h0, lw});
    end else if (ph == PH_ADDR && info.ddr) begin
      // both edges; first bit on rising after opcode
      if (cnt == 6'h00) begin
        next_sh  = {sh[27:0], io_in};
        next_cnt = NIB_BITS;
      end else if (cnt == tgt - NIB_BITS) begin
        next_sh  = {sh[27:0], neg_nib};
        next_cnt = tgt;
      end else begin
        next_sh  = {sh[23:0], neg_nib, io_in};
        next_cnt = cnt + NIB_BITS + NIB_BITS;
      end
    end
  end

  // boot state into the link domain
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      en_s <= 2'h0;
    end else begin
      en_s <= {en_s[0], link_en};
    end
  end

  // frame sequencer on rising edges
  always_ff @(posedge sck or posedge cs_n or negedge reset_n) begin
    if (!reset_n || cs_n) begin
      st        <= PH_START;
      cnt       <= 6'h00;
      sh        <= 32'h0;
      addr      <= 24'h0;
      dly       <= 4'h0;
      rbyte     <= 8'h00;
      seen_rise <= 1'b0;
      wr_data   <= 8'h00;
      wr_stb    <= 1'b0;
    end else begin
      seen_rise <= 1'b1;
      wr_stb    <= 1'b0;
      unique case (ph)
        PH_OPC: begin
          sh  <= next_sh;
          cnt <= next_cnt;
          st  <= PH_OPC;
          if (next_cnt == OPC_BITS) begin
            cnt <= 6'h00;
            if (!new_inf.ok) begin
              st <= PH_IGNORE;
            end else if (new_inf.rs1) begin
              rbyte <= cur_cfg.sr1;
              st    <= PH_DATA;
            end else begin
              st <= PH_ADDR;
            end
          end
        end
        PH_ADDR: begin
          // address msb first, mode byte after it
          sh  <= next_sh;
          cnt <= next_cnt;
          st  <= PH_ADDR;
          if (next_cnt == tgt) begin
            cnt  <= 6'h00;
            addr <= info.mode ? next_sh[31:8] : next_sh[23:0];
            rbyte <= 8'h00;
            if (next_sh[31:8] == RA_SR1_NV || next_sh[31:8] == RA_SR1_V ||
                (!info.mode && (next_sh[23:0] == RA_SR1_NV ||
                                next_sh[23:0] == RA_SR1_V))) begin
              rbyte <= cur_cfg.sr1;
            end
            if (!info.rd) begin
              st <= PH_DATA;
            end else if (info.ddr) begin
              // this edge is already the first wait cycle
              st  <= (wsel <= 4'h1) ? PH_DATA : PH_DUMMY;
              dly <= (wsel <= 4'h1) ? 4'h0 : wsel - 4'h2;
            end else begin
              st  <= (wsel == 4'h0) ? PH_DATA : PH_DUMMY;
              dly <= (wsel == 4'h0) ? 4'h0 : wsel - 4'h1;
            end
          end
        end
        PH_DUMMY: begin
          // one rising edge per wait cycle, lines ignored
          if (dly == 4'h0) begin
            st <= PH_DATA;
          end else begin
            dly <= dly - 4'h1;
          end
        end
        PH_DATA: begin
          if (!info.rd) begin
            sh  <= next_sh;
            cnt <= next_cnt;
            if (next_cnt == OPC_BITS) begin
              cnt     <= 6'h00;
              wr_data <= next_sh[7:0];
              wr_stb  <= 1'b1;
            end
          end
        end
        PH_IGNORE, PH_START: begin
          st <= PH_IGNORE;
        end
      endcase
    end
  end

  // operation and execute_in_place, kept across frames
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      xip  <= 1'b0;
      info <= '0;
    end else if (!en_s[1]) begin
      xip <= 1'b0;
    end else if (!cs_n) begin
      if (ph == PH_OPC && next_cnt == OPC_BITS) begin
        info <= new_inf;  // repeated while armed
      end
      if (ph == PH_ADDR && next_cnt == tgt) begin
        // mode byte decides continuation
        xip <= info.mode && (info.a5 ? (next_sh[7:0] == KEY_A5)
                                     : (next_sh[7:4] == KEY_HI));
      end
    end
  end

  assign src     = info.regs ? rbyte : mem_rdata;
  assign ld_byte = (st == PH_DATA) && info.rd && (info.ddr || ocnt == 4'h0);

  // falling edge sampling, mode detect and output drive
  always_ff @(negedge sck or posedge cs_n or negedge reset_n) begin
    if (!reset_n || cs_n) begin
      neg_nib <= 4'h0;
      mode3   <= 1'b0;
      io_oe   <= 4'h0;
      out_neg <= 4'h0;
      obyte   <= 8'h00;
      ocnt    <= 4'h0;
      dlo     <= 4'h0;
    end else begin
      neg_nib <= io_in;
      if (!seen_rise) begin
        mode3 <= 1'b1;  // clock was high at select
      end
      if (ld_byte && info.ddr) begin
        // first bit on falling edge ending last wait
        out_neg <= src[7:4];
        dlo     <= src[3:0];
        io_oe   <= 4'hf;
      end else if (ld_byte) begin
        out_neg <= drive_f(src, lw);
        obyte   <= src << lw;
        ocnt    <= 4'h8 - {1'b0, lw};
        io_oe   <= drive_f(8'hff, lw) | ((lw == 3'h1) ? 4'h2 : 4'h0);
      end else if (st == PH_DATA && info.rd) begin
        out_neg <= drive_f(obyte, lw);
        obyte   <= obyte << lw;
        ocnt    <= ocnt - {1'b0, lw};
      end
    end
  end

  // ddr low nibble on the rising edge
  always_ff @(posedge sck or posedge cs_n or negedge reset_n) begin
    if (!reset_n || cs_n) begin
      out_pos <= 4'h0;
    end else begin
      out_pos <= dlo;
    end
  end

  assign io_out = (info.ddr && sck) ? out_pos : out_neg;

  // array location, advances per byte moved
  always_ff @(negedge sck or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr <= 20'h0;
    end else if (st != PH_DATA) begin
      mem_addr <= addr[LOC_BITS-1:0];
    end else if (ld_byte || wr_stb) begin
      mem_addr <= mem_addr + 20'h1;
    end
  end

  // ---------------- checks ----------------
  a_boot_holdoff: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (bst == B_WAIT) |=> !link_en)
    else $error("link enabled during powerup delay");

  a_delay_length: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (bst == B_WAIT && !pu_done && sup_s[1]) |=> (bst == B_WAIT))
    else $error("powerup delay ended early");

  a_deep_entry: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (bst == B_RDY && cs_s[1] && sup_s[1] && nv_cfg.cr4[DEEP_BIT])
      |=> ##1 deep_pd && !standby)
    else $error("deep sleep not entered");

  a_boot_signature: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    boot_error |-> (cur_cfg.sr1 == BOOT_SIG))
    else $error("boot error signature wrong");

  a_boot_fallback: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(boot_error) |-> cur_cfg.cr2[LINE3_BIT] && !cur_cfg.cr2[QPI_BIT] &&
      !cur_cfg.cr2[DPI_BIT] && cur_cfg.cr2[RLAT_LSB +: 2] == RLAT_MAX)
    else $error("boot fallback settings wrong");

  a_err_cleared: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(link_en) |-> (err_regs == ERR_RST))
    else $error("error registers not cleared");

  a_xip_skip_opc: assert property (
    @(posedge sck) disable iff (!reset_n || cs_n)
    (st == PH_START && en_s[1] && xip) |-> (ph == PH_ADDR))
    else $error("armed frame did not skip opcode");

  a_xip_no_mode: assert property (
    @(posedge sck) disable iff (!reset_n || cs_n)
    (ph == PH_ADDR && next_cnt == tgt && !info.mode) |=> !xip)
    else $error("opcode without mode armed xip");

  a_xip_bad_key: assert property (
    @(posedge sck) disable iff (!reset_n || cs_n)
    (ph == PH_ADDR && next_cnt == tgt && next_sh[7:4] != KEY_HI &&
     next_sh[7:0] != KEY_A5) |=> !xip)
    else $error("wrong mode byte kept xip");

  a_one_opcode: assert property (
    @(posedge sck) disable iff (!reset_n || cs_n)
    (st != PH_START && st != PH_OPC) |=> (st != PH_OPC))
    else $error("second opcode phase in frame");

  a_wait_quiet: assert property (
    @(posedge sck) disable iff (!reset_n || cs_n)
    (st == PH_DUMMY) |-> (io_oe == 4'h0))
    else $error("lines driven during wait");

  c_xip_armed: cover property (
    @(posedge sck) disable iff (!reset_n) $rose(xip));
  c_boot_error: cover property (
    @(posedge ref_clk) disable iff (!reset_n) $rose(boot_error));
  c_deep_sleep: cover property (
    @(posedge ref_clk) disable iff (!reset_n) $rose(deep_pd));
  c_mode3_frame: cover property (
    @(posedge ref_clk) disable iff (!reset_n) $rose(spi_mode3));

endmodule  // xip_frontend

// ===== bench/spi_host.sv
`timescale 1ns/1ns
module spi_host (
  output logic            sck,    // link clock, idles low, high after a mode 3 frame
  output logic            cs_n,   // chip select
  output logic      [3:0] io_in,  // host to device lines
  input  wire logic [3:0] io_out  // device to host lines
);
  localparam int HALF = 80;  // half of the 160 ns link period
  // idle levels: clock stands still between frames
  initial begin
    sck = 1'b0;  // ddr frames are never run in mode 3
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // bit set while sck low, device takes it on the rise; reply read at the rise
  task automatic shift(input logic [31:0] v, input int n, inout logic [7:0] r);
    for (int i = n - 1; i >= 0; i--) begin
      io_in[0] = v[i];
      #HALF sck = 1'b1;
      r = {r[6:0], io_out[1]};
      #HALF sck = 1'b0;
    end
  endtask
  // one selected frame, single sdr; rd holds the last eight returned bits
  // m3 starts the frame with the clock high, as a mode 3 host does
  task automatic frame(input logic [7:0] op, input logic use_op, input logic [31:0] pay,
                       input int npay, input int waits, output logic [7:0] rd,
                       input logic m3 = 1'b0);
    rd = 8'h00;
    #3 sck = m3;  // idle level of this mode, edges kept off the system clock
    #HALF cs_n = 1'b0;
    #HALF;
    if (m3) begin
      sck = 1'b0;  // first edge falls, so the device sees mode 3
      #HALF;
    end
    if (use_op) shift({24'h0, op}, 8, rd);
    shift(pay, npay, rd);
    shift(32'h0, waits + 8, rd);  // wait cycles, then data
    #HALF cs_n = 1'b1;
    sck = m3;  // back to the idle level of this mode
    io_in = ~io_in;  // released lines do not keep the last value
  endtask
endmodule // spi_host

// ===== bench/xip_frontend_test.sv
`timescale 1ns/1ns
module xip_frontend_test;
  import xip_pkg::*;
  typedef struct {logic [7:0] op; logic use_op; int npay; logic [7:0] mode; logic xip;} row_t;
  localparam cfg_t        NV   = '{8'h3c, 8'h02, 8'h01, 8'h00};  // memory wait 2
  localparam logic [23:0] ADDR = 24'h012345;                    // test location
  logic ref_clk, reset_n, supply_ok, boot_fault;  // system side
  logic sck, cs_n;                                // link
  logic [3:0] io_in, io_out;                      // data lines
  logic [19:0] mem_addr;                          // array location
  logic [7:0] rd;                                 // byte read back
  cfg_t nv_cfg, cur_cfg;                          // registers
  err_t err_regs;                                 // error registers
  logic standby, deep_pd, boot_error, xip_active; // status
  logic spi_mode3, saw_m3 = 1'b0;                 // mode 3 seen in a frame
  int failures, n_compared;                       // counters
  row_t rows[6] = '{'{OP_RD_XIP, 1, 32, 8'ha3, 1}, '{OP_RD_XIP, 0, 32, 8'ha0, 1},
    '{OP_RD_XIP, 0, 32, 8'h5a, 0}, '{OP_RD_XIP, 1, 32, 8'ha5, 1},
    '{OP_RD_XIP, 0, 32, 8'h00, 0}, '{OP_RD_PLAIN, 1, 24, 8'ha0, 0}};
  xip_frontend #(.PU_CYCLES(20)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .supply_ok(supply_ok), .boot_fault(boot_fault), .nv_cfg(nv_cfg), .sck(sck),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(), .mem_addr(mem_addr),
    .mem_rdata(mem_addr[7:0] ^ 8'h5a), .wr_data(), .wr_stb(), .cur_cfg(cur_cfg),
    .err_regs(err_regs), .standby(standby), .deep_pd(deep_pd), .boot_error(boot_error),
    .xip_active(xip_active), .spi_mode3(spi_mode3));
  spi_host u_host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));
  // remember any frame that the device took as mode 3
  always @(posedge ref_clk) begin
    if (spi_mode3 === 1'b1) saw_m3 <= 1'b1;
  end
  // system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // reset, wait out the powerup delay, then a dummy frame to wake the link
  task automatic boot(input logic fault);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    boot_fault <= fault;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 200 && standby !== 1'b1 && deep_pd !== 1'b1 && boot_error !== 1'b1;
         i++) begin
      @(posedge ref_clk);  // no frame before boot ends
    end
    check(standby | deep_pd | boot_error, 1'b1);
    check(xip_active, 1'b0);
    u_host.frame(8'h00, 1'b1, 32'h0, 0, 0, rd);
  endtask
  // give up if the run hangs
  initial begin
    #900000;
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    failures = 0;
    n_compared = 0;
    reset_n = 1'b0;
    supply_ok = 1'b1;
    boot_fault = 1'b0;
    nv_cfg = NV;
    boot(1'b0);
    check(cur_cfg, NV);
    check(err_regs, 96'h0);
    check({standby, deep_pd}, 2'b10);
    u_host.frame(OP_RD_STAT1, 1'b1, 32'h0, 0, 0, rd);
    check(rd, NV.sr1);
    foreach (rows[i]) begin
      u_host.frame(rows[i].op, rows[i].use_op, (rows[i].npay == 32) ? {ADDR, rows[i].mode}
                   : {8'h00, ADDR}, rows[i].npay, 2, rd);
      repeat (20) @(posedge ref_clk);
      check(rd, ADDR[7:0] ^ 8'h5a);
      check(xip_active, rows[i].xip);
    end
    check(saw_m3, 1'b0);
    u_host.frame(OP_RD_STAT1, 1'b1, 32'h0, 0, 0, rd, 1'b1);
    check(rd, NV.sr1);
    check(saw_m3, 1'b1);
    u_host.frame(OP_RD_XIP, 1'b1, {ADDR, 8'ha0}, 32, 2, rd);
    check(xip_active, 1'b1);
    nv_cfg.cr4[DEEP_BIT] <= 1'b1;
    boot(1'b0);
    check({standby, deep_pd}, 2'b01);
    nv_cfg <= NV;
    boot(1'b1);
    check(boot_error, 1'b1);
    check({cur_cfg.cr2[LINE3_BIT], cur_cfg.cr2[1:0]}, {1'b1, RLAT_MAX});
    u_host.frame(OP_RD_STAT1, 1'b1, 32'h0, 0, 0, rd);
    check(rd, BOOT_SIG);
    u_host.frame(OP_RD_ANY, 1'b1, {8'h00, RA_SR1_V}, 24, 3, rd);
    check(rd, BOOT_SIG);
    finish_test();
  end
endmodule // xip_frontend_test
